/* File: design/inl_pkg.sv */
// constants, types and register map shared by the nibble store and display driver
package inl_pkg;
	localparam int          ADDR_W            = 10;
	localparam int          NIB_W             = 4;
	// register indices; byte address is four times the index
	localparam logic [6:0]  IDX_DIRECT_LAST   = 7'h3f;
	localparam logic [6:0]  IDX_INDEXED_BASE0 = 7'h40;
	localparam logic [6:0]  IDX_INDEXED_BASE3 = 7'h43;
	localparam logic [6:0]  IDX_SEG_BASE1     = 7'h44;
	localparam logic [6:0]  IDX_SEG_BASE3     = 7'h46;
	localparam logic [6:0]  IDX_OFFSET_PTR    = 7'h70;
	localparam logic [6:0]  IDX_STROBE_PUMP   = 7'h71;
	localparam logic [6:0]  IDX_POWER_CTRL    = 7'h72;
	localparam logic [6:0]  IDX_STATUS        = 7'h73;
	// field positions
	localparam int          STROBE_SEL_HI     = 3;
	localparam int          STROBE_SEL_LO     = 2;
	localparam int          PUMP_SEL_HI       = 1;
	localparam int          PUMP_SEL_LO       = 0;
	localparam int          BLANK_BIT         = 3;
	localparam int          OFF_BIT           = 2;
	localparam int          FOUR_PHASE_BIT    = 1;
	localparam int          EXT_BIAS_BIT      = 0;
	// values after reset
	localparam logic [1:0]  STROBE_SEL_RST    = 2'h0;
	localparam logic [1:0]  PUMP_SEL_RST      = 2'h0;
	localparam logic [2:0]  POWER_CTRL_RST    = 3'h7;
	localparam logic        EXT_BIAS_RST      = 1'h0;
	localparam logic [3:0]  OFFSET_PTR_RST    = 4'h0;
	// segment latch locations that hold a latch
	localparam logic [5:0]  SEG_LOC_FIRST     = 6'h01;
	localparam logic [5:0]  SEG_LOC_LAST      = 6'h20;
	// timing
	localparam int          SYS_CLK_HZ        = 25_000_000;
	localparam int          PRESC_TICK_HZ     = 1024;
	localparam int          PRESC_TICK_CYC    = SYS_CLK_HZ / PRESC_TICK_HZ;
	localparam int          LCD_CLK_HZ        = 256;
	localparam logic [1:0]  LCD_TICK_PHASE    = 2'(PRESC_TICK_HZ / LCD_CLK_HZ - 1);
	// bus answers
	localparam logic [1:0]  RESP_OKAY         = 2'h0;
	localparam logic [1:0]  RESP_SLVERR       = 2'h2;

	typedef enum logic [1:0] {
		STB_RESET    = 2'b00,
		STB_RESET_PB = 2'b01,
		STB_PORT_B   = 2'b10,
		STB_SLEEP    = 2'b11
	} inl_strobe_src_t;

	typedef struct packed {
		logic blank;
		logic off;
		logic four_phase;
		logic ext_bias;
	} inl_lcd_ctrl_t;

	typedef struct packed {
		inl_strobe_src_t strobe_sel;
		logic [1:0]      pump_sel;
	} inl_strobe_pump_t;
endpackage

/* File: design/inl_nibble_store.sv */
// nibble-wide storage array with one write port and one read port
module inl_nibble_store #(
	parameter int DEPTH = 64,
	parameter int AW    = 6,
	parameter int DW    = 4
) (
	input  wire logic          clk_sys,
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [DW-1:0] wr_data,
	input  wire logic [AW-1:0] rd_addr,
	output      logic [DW-1:0] rd_data
);
	// contents are undefined after reset, as software expects
	logic [DW-1:0] mem_r [DEPTH];

	always_ff @(posedge clk_sys) begin
		if (wr_en) begin
			mem_r[wr_addr] <= wr_data;
		end
	end

	assign rd_data = mem_r[rd_addr];
endmodule

/* File: design/inl_seg_scan.sv */
// segment latches and the phase scan that drives segments and backplanes
module inl_seg_scan #(
	parameter int NSEG = 32,
	parameter int NPH  = 4
) (
	input  wire logic                  clk_sys,
	input  wire logic                  nrst,
	input  wire logic                  lcd_tick,
	input  wire inl_pkg::inl_lcd_ctrl_t ctrl,
	input  wire logic                  wr_en,
	input  wire logic [5:0]            wr_loc,
	input  wire logic [3:0]            wr_data,
	input  wire logic [5:0]            rd_loc,
	output      logic [3:0]            rd_data,
	output      logic [NSEG-1:0]       seg_r,
	output      logic [NPH-1:0]        bp_r,
	output      logic                  pol_r,
	output      logic [1:0]            phase_r
);
	logic [3:0] latch_r [NSEG];
	logic       wr_hit;
	logic       rd_hit;
	logic [5:0] wr_slot;
	logic [5:0] rd_slot;
	logic [1:0] last_phase;
	logic       seg_dark;

	// location n holds the latch of segment n; location 0 and 33..47 stay empty
	assign wr_hit     = (wr_loc >= inl_pkg::SEG_LOC_FIRST) && (wr_loc <= inl_pkg::SEG_LOC_LAST);
	assign rd_hit     = (rd_loc >= inl_pkg::SEG_LOC_FIRST) && (rd_loc <= inl_pkg::SEG_LOC_LAST);
	assign wr_slot    = wr_loc - inl_pkg::SEG_LOC_FIRST;
	assign rd_slot    = rd_loc - inl_pkg::SEG_LOC_FIRST;
	assign rd_data    = rd_hit ? latch_r[rd_slot[4:0]] : 4'h0;
	assign last_phase = ctrl.four_phase ? 2'h3 : 2'h2;
	assign seg_dark   = ctrl.blank | ctrl.off;

	// latches have no reset: blank is set after reset, so nothing stale shows
	always_ff @(posedge clk_sys) begin
		if (wr_en && wr_hit) begin
			latch_r[wr_slot[4:0]] <= wr_data;
		end
	end

	// each phase lasts two display clocks, one per drive polarity
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			pol_r   <= 1'b0;
			phase_r <= 2'h0;
		end else if (lcd_tick) begin
			pol_r <= ~pol_r;
			if (pol_r) begin
				phase_r <= (phase_r >= last_phase) ? 2'h0 : phase_r + 2'h1;
			end
		end
	end

	genvar k;
	generate
		for (k = 0; k < NSEG; k++) begin : g_seg
			always_ff @(posedge clk_sys or negedge nrst) begin
				if (!nrst) begin
					seg_r[k] <= 1'b0;
				end else begin
					seg_r[k] <= ~seg_dark & latch_r[k][phase_r];
				end
			end
		end
		for (k = 0; k < NPH; k++) begin : g_bp
			always_ff @(posedge clk_sys or negedge nrst) begin
				if (!nrst) begin
					bp_r[k] <= 1'b0;
				end else begin
					bp_r[k] <= ~ctrl.off & (phase_r == 2'(k)) & (2'(k) <= last_phase);
				end
			end
		end
	endgenerate
endmodule

/* File: design/inl_top.sv */
// indexed nibble memory and segment display control behind an AXI4-Lite slave
// Overview of operation
// - direct 64-nibble store at addresses 0..63
// - indexed 64-nibble store via bases 64..67
// - 32 segment outputs, 4 backplanes
// - 256 Hz clock, frame /8 or /6
// - external bias disables regulator, bias high-Z
// - external bias cleared by power-on only
// - multiplex select; three-phase keeps backplane four off
// - display off stops supply, grounds bias, keeps latches
// - blank forces segments off, supply stays on
// - pump clock select cleared by every reset
// - strobe select bits 3:2, pump bits 1:0
// - segment latches indexed from three bases, read/write
// - third base: only index 0 usable
// - 48 locations, exactly 32 nibble latches
// - pump select picks prescaler tap 512..64 Hz
// - strobe select picks reset, port-B write, sleep
// - segment shows latch bit n during phase n
// - power control bit layout and reset values
module inl_top #(
	parameter int PRESC_TICK_CYC = inl_pkg::PRESC_TICK_CYC,
	parameter int NSEG           = 32,
	parameter int NPH            = 4
) (
	input  wire logic                       clk_sys,
	input  wire logic                       nrst,
	input  wire logic                       por_n,
	input  wire logic [inl_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output      logic                       s_axi_awready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output      logic                       s_axi_wready,
	output      logic [1:0]                 s_axi_bresp,
	output      logic                       s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [inl_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output      logic                       s_axi_arready,
	output      logic [31:0]                s_axi_rdata,
	output      logic [1:0]                 s_axi_rresp,
	output      logic                       s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	input  wire logic                       cpu_reset_active,
	input  wire logic                       port_b_write_pulse,
	input  wire logic                       sleep_active,
	output      logic                       strobe_out,
	output      logic [NSEG-1:0]            pixel_line_output,
	output      logic [NPH-1:0]             backplane_out,
	output      logic                       frame_polarity,
	output      logic                       pump_clk,
	output      logic                       regulator_en,
	output      logic [2:0]                 bias_out,
	output      logic [2:0]                 bias_oe
);
	// bus state
	logic                       awready_r;
	logic                       wready_r;
	logic                       aw_held_r;
	logic                       w_held_r;
	logic [inl_pkg::ADDR_W-1:0] awaddr_r;
	logic [3:0]                 wnib_r;
	logic                       wlane_r;
	logic                       bvalid_r;
	logic [1:0]                 bresp_r;
	logic                       arready_r;
	logic                       rd_pend_r;
	logic [inl_pkg::ADDR_W-1:0] araddr_r;
	logic                       rvalid_r;
	logic [31:0]                rdata_r;
	logic [1:0]                 rresp_r;
	// control registers
	logic [3:0]                 offset_pointer_r;
	inl_pkg::inl_strobe_src_t   strobe_sel_r;
	logic [1:0]                 pump_sel_r;
	logic                       blank_r;
	logic                       off_r;
	logic                       four_phase_r;
	logic                       ext_bias_r;
	inl_pkg::inl_lcd_ctrl_t     lcd_ctrl;
	inl_pkg::inl_strobe_pump_t  strobe_pump;
	// clocks and outputs
	logic [15:0]                presc_cnt_r;
	logic [3:0]                 ck_div_r;
	logic                       presc_tick;
	logic                       lcd_tick;
	logic                       pump_tap;
	logic                       strobe_nxt;
	logic                       strobe_r;
	logic                       pump_clk_r;
	logic                       regulator_en_r;
	logic [2:0]                 bias_out_r;
	logic [2:0]                 bias_oe_r;
	logic [1:0]                 phase;
	// write decode
	logic [6:0]                 w_idx;
	logic                       w_do;
	logic                       w_in_range;
	logic                       w_direct;
	logic                       w_indexed;
	logic                       w_seg;
	logic                       w_ptr;
	logic                       w_sp;
	logic                       w_pc;
	logic                       w_mapped;
	// read decode
	logic [6:0]                 r_idx;
	logic                       r_in_range;
	logic                       r_direct;
	logic                       r_indexed;
	logic                       r_seg;
	logic                       r_mapped;
	logic [3:0]                 direct_rd;
	logic [3:0]                 indexed_rd;
	logic [3:0]                 seg_rd;
	logic [3:0]                 r_nib;
	logic [5:0]                 w_seg_loc;
	logic [5:0]                 r_seg_loc;
	logic [5:0]                 w_ind_addr;
	logic [5:0]                 r_ind_addr;
	logic                       aw_take;
	logic                       w_take;
	logic                       ar_take;
	logic                       b_done;
	logic                       r_done;

	assign aw_take = s_axi_awvalid & awready_r;
	assign w_take  = s_axi_wvalid & wready_r;
	assign ar_take = s_axi_arvalid & arready_r;
	assign b_done  = bvalid_r & s_axi_bready;
	assign r_done  = rvalid_r & s_axi_rready;
	assign w_do    = aw_held_r & w_held_r & ~bvalid_r;

	// write address decode; anything above the map answers with an error
	assign w_idx      = awaddr_r[8:2];
	assign w_in_range = ~awaddr_r[inl_pkg::ADDR_W-1];
	assign w_direct   = w_in_range & (w_idx <= inl_pkg::IDX_DIRECT_LAST);
	assign w_indexed  = w_in_range & (w_idx >= inl_pkg::IDX_INDEXED_BASE0) & (w_idx <= inl_pkg::IDX_INDEXED_BASE3);
	assign w_seg      = w_in_range & (w_idx >= inl_pkg::IDX_SEG_BASE1) & (w_idx <= inl_pkg::IDX_SEG_BASE3);
	assign w_ptr      = w_in_range & (w_idx == inl_pkg::IDX_OFFSET_PTR);
	assign w_sp       = w_in_range & (w_idx == inl_pkg::IDX_STROBE_PUMP);
	assign w_pc       = w_in_range & (w_idx == inl_pkg::IDX_POWER_CTRL);
	assign w_mapped   = w_direct | w_indexed | w_seg | w_ptr | w_sp | w_pc | (w_in_range & (w_idx == inl_pkg::IDX_STATUS));
	// base block times sixteen plus the offset pointer
	assign w_ind_addr = {w_idx[1:0], offset_pointer_r};
	assign w_seg_loc  = {w_idx[1:0], offset_pointer_r};

	// read address decode
	assign r_idx      = araddr_r[8:2];
	assign r_in_range = ~araddr_r[inl_pkg::ADDR_W-1];
	assign r_direct   = r_in_range & (r_idx <= inl_pkg::IDX_DIRECT_LAST);
	assign r_indexed  = r_in_range & (r_idx >= inl_pkg::IDX_INDEXED_BASE0) & (r_idx <= inl_pkg::IDX_INDEXED_BASE3);
	assign r_seg      = r_in_range & (r_idx >= inl_pkg::IDX_SEG_BASE1) & (r_idx <= inl_pkg::IDX_SEG_BASE3);
	assign r_mapped   = r_direct | r_indexed | r_seg | (r_in_range & (r_idx >= inl_pkg::IDX_OFFSET_PTR)
		& (r_idx <= inl_pkg::IDX_STATUS));
	assign r_ind_addr = {r_idx[1:0], offset_pointer_r};
	assign r_seg_loc  = {r_idx[1:0], offset_pointer_r};

	assign lcd_ctrl    = '{blank: blank_r, off: off_r, four_phase: four_phase_r, ext_bias: ext_bias_r};
	assign strobe_pump = '{strobe_sel: strobe_sel_r, pump_sel: pump_sel_r};

	assign r_nib = r_direct  ? direct_rd :
		r_indexed ? indexed_rd :
		r_seg     ? seg_rd :
		(r_idx == inl_pkg::IDX_OFFSET_PTR)  ? offset_pointer_r :
		(r_idx == inl_pkg::IDX_STROBE_PUMP) ? strobe_pump :
		(r_idx == inl_pkg::IDX_POWER_CTRL)  ? lcd_ctrl :
		(r_idx == inl_pkg::IDX_STATUS)      ? {phase, frame_polarity, regulator_en_r} : 4'h0;

	inl_nibble_store #(
		.DEPTH (64),
		.AW    (6),
		.DW    (inl_pkg::NIB_W)
	) u_direct (
		.clk_sys (clk_sys),
		.wr_en   (w_do & wlane_r & w_direct),
		.wr_addr (w_idx[5:0]),
		.wr_data (wnib_r),
		.rd_addr (r_idx[5:0]),
		.rd_data (direct_rd)
	);

	inl_nibble_store #(
		.DEPTH (64),
		.AW    (6),
		.DW    (inl_pkg::NIB_W)
	) u_indexed (
		.clk_sys (clk_sys),
		.wr_en   (w_do & wlane_r & w_indexed),
		.wr_addr (w_ind_addr),
		.wr_data (wnib_r),
		.rd_addr (r_ind_addr),
		.rd_data (indexed_rd)
	);

	inl_seg_scan #(
		.NSEG (NSEG),
		.NPH  (NPH)
	) u_scan (
		.clk_sys  (clk_sys),
		.nrst     (nrst),
		.lcd_tick (lcd_tick),
		.ctrl     (lcd_ctrl),
		.wr_en    (w_do & wlane_r & w_seg),
		.wr_loc   (w_seg_loc),
		.wr_data  (wnib_r),
		.rd_loc   (r_seg_loc),
		.rd_data  (seg_rd),
		.seg_r    (pixel_line_output),
		.bp_r     (backplane_out),
		.pol_r    (frame_polarity),
		.phase_r  (phase)
	);

	// write channel: address and data may arrive in either order
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			awready_r <= 1'b1;
			wready_r  <= 1'b1;
			aw_held_r <= 1'b0;
			w_held_r  <= 1'b0;
			awaddr_r  <= '0;
			wnib_r    <= 4'h0;
			wlane_r   <= 1'b0;
			bvalid_r  <= 1'b0;
			bresp_r   <= inl_pkg::RESP_OKAY;
		end else begin
			if (aw_take) begin
				awready_r <= 1'b0;
				aw_held_r <= 1'b1;
				awaddr_r  <= s_axi_awaddr;
			end
			if (w_take) begin
				wready_r <= 1'b0;
				w_held_r <= 1'b1;
				wnib_r   <= s_axi_wdata[3:0];
				wlane_r  <= s_axi_wstrb[0];
			end
			if (w_do) begin
				aw_held_r <= 1'b0;
				w_held_r  <= 1'b0;
				bvalid_r  <= 1'b1;
				bresp_r   <= w_mapped ? inl_pkg::RESP_OKAY : inl_pkg::RESP_SLVERR;
			end
			if (b_done) begin
				bvalid_r  <= 1'b0;
				awready_r <= 1'b1;
				wready_r  <= 1'b1;
			end
		end
	end

	// read channel: one cycle to look up, then hold until taken
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			arready_r <= 1'b1;
			rd_pend_r <= 1'b0;
			araddr_r  <= '0;
			rvalid_r  <= 1'b0;
			rdata_r   <= 32'h0000_0000;
			rresp_r   <= inl_pkg::RESP_OKAY;
		end else begin
			if (ar_take) begin
				arready_r <= 1'b0;
				rd_pend_r <= 1'b1;
				araddr_r  <= s_axi_araddr;
			end
			if (rd_pend_r) begin
				rd_pend_r <= 1'b0;
				rvalid_r  <= 1'b1;
				rdata_r   <= {28'h0000000, r_nib};
				rresp_r   <= r_mapped ? inl_pkg::RESP_OKAY : inl_pkg::RESP_SLVERR;
			end
			if (r_done) begin
				rvalid_r  <= 1'b0;
				arready_r <= 1'b1;
			end
		end
	end

	// registers loaded with their reset values by every system reset; blank, off and four-phase come up set
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			offset_pointer_r <= inl_pkg::OFFSET_PTR_RST;
			pump_sel_r       <= inl_pkg::PUMP_SEL_RST;
			{blank_r, off_r, four_phase_r} <= inl_pkg::POWER_CTRL_RST;
		end else if (w_do && wlane_r) begin
			if (w_ptr) begin
				offset_pointer_r <= wnib_r;
			end
			if (w_sp) begin
				pump_sel_r <= wnib_r[inl_pkg::PUMP_SEL_HI:inl_pkg::PUMP_SEL_LO];
			end
			if (w_pc) begin
				blank_r      <= wnib_r[inl_pkg::BLANK_BIT];
				off_r        <= wnib_r[inl_pkg::OFF_BIT];
				four_phase_r <= wnib_r[inl_pkg::FOUR_PHASE_BIT];
			end
		end
	end

	// registers that only power-on clears; a system reset leaves them alone
	always_ff @(posedge clk_sys or negedge por_n) begin
		if (!por_n) begin
			strobe_sel_r <= inl_pkg::STB_RESET;
			ext_bias_r   <= inl_pkg::EXT_BIAS_RST;
		end else if (w_do && wlane_r) begin
			if (w_sp) begin
				strobe_sel_r <= inl_pkg::inl_strobe_src_t'(wnib_r[inl_pkg::STROBE_SEL_HI:inl_pkg::STROBE_SEL_LO]);
			end
			if (w_pc) begin
				ext_bias_r <= wnib_r[inl_pkg::EXT_BIAS_BIT];
			end
		end
	end

	// prescaler: 1024 Hz tick, then binary taps for 512/256/128/64 Hz
	assign presc_tick = (presc_cnt_r == 16'(PRESC_TICK_CYC - 1));
	assign lcd_tick   = presc_tick & (ck_div_r[1:0] == inl_pkg::LCD_TICK_PHASE);

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			presc_cnt_r <= 16'h0000;
			ck_div_r    <= 4'h0;
		end else begin
			presc_cnt_r <= presc_tick ? 16'h0000 : presc_cnt_r + 16'h0001;
			if (presc_tick) begin
				ck_div_r <= ck_div_r + 4'h1;
			end
		end
	end

	assign pump_tap = ck_div_r[pump_sel_r];

	always_comb begin
		unique case (strobe_sel_r)
			inl_pkg::STB_RESET:    strobe_nxt = cpu_reset_active;
			inl_pkg::STB_RESET_PB: strobe_nxt = cpu_reset_active | port_b_write_pulse;
			inl_pkg::STB_PORT_B:   strobe_nxt = port_b_write_pulse;
			inl_pkg::STB_SLEEP:    strobe_nxt = sleep_active;
		endcase
	end

	// external bias wins over display-off: pins float rather than short an outside supply
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			strobe_r       <= 1'b0;
			pump_clk_r     <= 1'b0;
			regulator_en_r <= 1'b0;
			bias_out_r     <= 3'h0;
			bias_oe_r      <= 3'h0;
		end else begin
			strobe_r       <= strobe_nxt;
			pump_clk_r     <= pump_tap & ~off_r & ~ext_bias_r;
			regulator_en_r <= ~off_r & ~ext_bias_r;
			bias_out_r     <= {3{~off_r & ~ext_bias_r}};
			bias_oe_r      <= {3{~ext_bias_r}};
		end
	end

	assign s_axi_awready = awready_r;
	assign s_axi_wready  = wready_r;
	assign s_axi_bvalid  = bvalid_r;
	assign s_axi_bresp   = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid  = rvalid_r;
	assign s_axi_rdata   = rdata_r;
	assign s_axi_rresp   = rresp_r;
	assign strobe_out    = strobe_r;
	assign pump_clk      = pump_clk_r;
	assign regulator_en  = regulator_en_r;
	assign bias_out      = bias_out_r;
	assign bias_oe       = bias_oe_r;
endmodule

/* File: sim/inl_chk.sv */
// bus and display checks bound to the top module
module inl_chk (
	input wire logic        clk_sys,
	input wire logic        nrst,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] pixel_line_output,
	input wire logic [3:0]  backplane_out,
	input wire logic        pump_clk,
	input wire logic        regulator_en,
	input wire logic [2:0]  bias_oe
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);
	wr_answer_a: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write answer late");
	rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
		else $error("read answer late");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write answer dropped");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
		else $error("read answer dropped");
	aw_block_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2])
		else $error("write taken while busy");
	bp_onehot_a: assert property ($onehot0(backplane_out))
		else $error("two backplanes active");
	seg_dark_a: assert property (backplane_out == 4'h0 |-> pixel_line_output == 32'h0)
		else $error("segments on without backplane");
	pump_off_a: assert property (!regulator_en |-> !pump_clk)
		else $error("pump runs while supply off");
	bias_drive_a: assert property (regulator_en |-> bias_oe == 3'h7)
		else $error("bias not driven while running");
	cover property (s_axi_bvalid && s_axi_bready);
	cover property (s_axi_rvalid && s_axi_rready);
	cover property (backplane_out[3]);
endmodule

/* File: sim/inl_panel.sv */
// panel model: holds the segment image seen under each backplane
module inl_panel (
	input  wire logic        clk_sys,
	input  wire logic [31:0] seg,
	input  wire logic [3:0]  com,
	output      logic [3:0][31:0] img
);
	timeunit 1ns;
	timeprecision 1ns;
	always @(posedge clk_sys)
		for (int p = 0; p < 4; p++)
			if (com[p]) img[p] <= seg;
endmodule

/* File: sim/inl_top_tb.sv */
// self-checking bench for the nibble store and display control block
module inl_top_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int TK = 16;
	logic        clk_sys = 0, nrst = 0, por_n = 0;
	logic [9:0]  awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, pix, ex;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic        rst_cpu = 0, pb = 0, slp = 0;
	logic [1:0]  bresp, rresp;
	logic        awready, wready, bvalid, arready, rvalid, strobe, pump, reg_en, pol;
	logic [3:0]  bp;
	logic [2:0]  bias, bias_oe;
	logic [3:0][31:0] img;
	logic [3:0]  lat [1:32];
	logic [33:0] q [$];
	int          n_mismatch = 0, tests_run = 0, cyc = 0, n3;
	always #20 clk_sys = ~clk_sys;
	inl_top #(.PRESC_TICK_CYC(4)) DUT (.clk_sys(clk_sys), .nrst(nrst), .por_n(por_n),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .cpu_reset_active(rst_cpu), .port_b_write_pulse(pb), .sleep_active(slp),
		.strobe_out(strobe), .pixel_line_output(pix), .backplane_out(bp), .frame_polarity(pol),
		.pump_clk(pump), .regulator_en(reg_en), .bias_out(bias), .bias_oe(bias_oe));
	inl_panel u_pan (.clk_sys(clk_sys), .seg(pix), .com(bp), .img(img));
	task automatic chk(input logic [33:0] s, input logic [33:0] e, input string m);
		tests_run++;
		if (s !== e) begin
			n_mismatch++;
			$display("wrong value at %0t: %s got %h want %h", $time, m, s, e);
		end
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [6:0] i, input logic [3:0] d, input logic [1:0] r = 2'h0);
		@(posedge clk_sys);
		q.push_back({r, 32'h0});
		awaddr <= {1'b0, i, 2'h0};
		wdata <= {28'h0, d};
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		do begin
			@(posedge clk_sys);
			if (awready) awvalid <= 0;
			if (wready) wvalid <= 0;
		end while (!bvalid);
		bready <= 0;
	endtask
	task automatic rd(input logic [6:0] i, input logic [3:0] d, input logic [1:0] r = 2'h0);
		@(posedge clk_sys);
		q.push_back({r, 28'h0, d});
		araddr <= {1'b0, i, 2'h0};
		arvalid <= 1;
		rready <= 1;
		do begin
			@(posedge clk_sys);
			if (arready) arvalid <= 0;
		end while (!rvalid);
		rready <= 0;
	endtask
	task automatic rst(input logic por);
		@(posedge clk_sys);
		nrst <= 0;
		por_n <= !por;
		repeat (4) @(posedge clk_sys);
		nrst <= 1;
		por_n <= 1;
	endtask
	function automatic logic sig(input int w);
		return w == 2 ? pol : w == 1 ? pump : bp[0];
	endfunction
	task automatic rise(input int w);
		do @(posedge clk_sys); while (sig(w));
		do @(posedge clk_sys); while (!sig(w));
	endtask
	// period between rising edges, in clocks
	task automatic per(input int w, input int e);
		time t;
		rise(w);
		t = $time;
		rise(w);
		chk(34'(($time - t) / 40), 34'(e), "period");
	endtask
	task automatic stb(input int s);
		logic [2:0] r;
		r = 3'($urandom);
		@(posedge clk_sys);
		rst_cpu <= r[2];
		pb <= r[1];
		slp <= r[0];
		@(posedge clk_sys);
		pb <= 0;
		#1;
		chk(34'(strobe), 34'(s == 0 ? r[2] : s == 1 ? r[2] | r[1] : s == 2 ? r[1] : r[0]), "strobe");
	endtask
	// one queue serves both answers: writes and reads never overlap here
	always @(posedge clk_sys) begin
		if (bvalid && bready) chk({bresp, 32'h0}, q.pop_front(), "write answer");
		if (rvalid && rready) chk({rresp, rdata}, q.pop_front(), "read data");
	end
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			give_verdict();
		end
	end
	initial begin
		logic [3:0] v, p;
		void'($urandom(32'h8b781a44));
		rst(1);
		rd(7'h71, 4'h0);
		rd(7'h72, 4'he);
		rd(7'h70, 4'h0);
		$display("done: reset values");
		v = 4'($urandom);
		wr(7'h00, v);
		wr(7'h3f, ~v);
		rd(7'h00, v);
		rd(7'h3f, ~v);
		p = 4'($urandom);
		wr(7'h70, p);
		for (int b = 0; b < 4; b++) wr(7'h40 + 7'(b), 4'(b + 3));
		wr(7'h70, 4'(p + 1));
		wr(7'h42, v);
		rd(7'h70, 4'(p + 1));
		rd(7'h42, v);
		wr(7'h70, p);
		for (int b = 0; b < 4; b++) rd(7'h40 + 7'(b), 4'(b + 3));
		rd(7'h00, v);
		$display("done: stores");
		for (int k = 1; k <= 32; k++) begin
			lat[k] = 4'($urandom);
			wr(7'h70, 4'(k));
			wr(7'h44 + 7'(k / 16), lat[k]);
		end
		wr(7'h70, 4'h0);
		wr(7'h44, 4'h5);
		rd(7'h44, 4'h0);
		wr(7'h70, 4'h8);
		wr(7'h46, 4'h5);
		rd(7'h46, 4'h0);
		rd(7'h50, 4'h0, 2'h2);
		wr(7'h50, 4'h1, 2'h2);
		wr(7'h70, 4'h0);
		rd(7'h46, lat[32]);
		$display("done: segment latches");
		wr(7'h72, 4'h2);
		repeat (300) @(posedge clk_sys);
		for (int ph = 0; ph < 4; ph++) begin
			for (int k = 1; k <= 32; k++) ex[k - 1] = lat[k][ph];
			chk(34'(img[ph]), 34'(ex), "phase image");
		end
		per(0, 8 * TK);
		for (int s = 0; s < 4; s++) begin
			wr(7'h71, 4'(s));
			per(1, (TK / 2) << s);
		end
		for (int s = 0; s < 4; s++) begin
			wr(7'h71, 4'(s << 2));
			repeat (4) stb(s);
		end
		wr(7'h72, 4'h0);
		per(0, 6 * TK);
		per(2, 2 * TK);
		n3 = 0;
		repeat (200) @(posedge clk_sys) n3 += int'(bp[3]);
		chk(34'(n3), 34'h0, "fourth backplane");
		rd(7'h46, lat[32]);
		$display("done: scan");
		wr(7'h72, 4'ha);
		repeat (40) @(posedge clk_sys);
		chk(34'({reg_en, pix}), 34'h1_0000_0000, "blank");
		wr(7'h72, 4'h6);
		repeat (4) @(posedge clk_sys);
		chk(34'({reg_en, bias, bias_oe}), 34'h07, "off");
		rd(7'h46, lat[32]);
		wr(7'h72, 4'h7);
		repeat (4) @(posedge clk_sys);
		chk(34'({reg_en, bias_oe}), 34'h0, "external bias");
		wr(7'h71, 4'hb);
		rst(0);
		rd(7'h71, 4'h8);
		rd(7'h72, 4'hf);
		rst(1);
		rd(7'h71, 4'h0);
		rd(7'h72, 4'he);
		rd(7'h73, 4'h0);
		$display("done: power control");
		give_verdict();
	end
endmodule
bind inl_top inl_chk u_chk (.clk_sys(clk_sys), .nrst(nrst), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.pixel_line_output(pixel_line_output), .backplane_out(backplane_out), .pump_clk(pump_clk),
	.regulator_en(regulator_en), .bias_oe(bias_oe));
